// ---- tfv_host_model.sv ----
// host-side register master model for the value/config bank
`timescale 1ns/100ps
`default_nettype none

module tfv_host_model
  import tfv_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // register port
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end

  // factory test location is never written, whatever a caller asks
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    if (a != ADDR_FACTORY_TEST) begin
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
    end
  endtask : wr_reg

  // bounded wait: a missing rvalid returns unknown data;
  // rvalid and data are taken at the edge that samples rvalid high
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    d = 8'hXX;
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      n++;
    end
    if (rvalid_in === 1'b1) d = rdata_in;
  endtask : rd_reg
endmodule : tfv_host_model

`default_nettype wire

// ---- tfv_pkg.sv ----
// constants and carrier types for the thermal/fan value and configuration bank
package tfv_pkg;

  // register addresses
  localparam logic [7:0] ADDR_INT_TRIP_PROG = 8'h13;
  localparam logic [7:0] ADDR_REM_TRIP_PROG = 8'h14;
  localparam logic [7:0] ADDR_FACTORY_TEST  = 8'h15;
  localparam logic [7:0] ADDR_INT_TRIP_FIX  = 8'h17;
  localparam logic [7:0] ADDR_REM_TRIP_FIX  = 8'h18;
  localparam logic [7:0] ADDR_FAN_SPEED     = 8'h19;
  localparam logic [7:0] ADDR_REM_TEMP      = 8'h26;
  localparam logic [7:0] ADDR_INT_TEMP      = 8'h27;
  localparam logic [7:0] ADDR_REM_HIGH      = 8'h37;
  localparam logic [7:0] ADDR_REM_LOW       = 8'h38;
  localparam logic [7:0] ADDR_INT_HIGH      = 8'h39;
  localparam logic [7:0] ADDR_INT_LOW       = 8'h3A;
  localparam logic [7:0] ADDR_CONFIG        = 8'h40;

  // reset and fixed values, degrees as signed 8-bit
  localparam logic [7:0] RST_INT_TRIP_PROG  = 8'h7F;
  localparam logic [7:0] RST_REM_TRIP_PROG  = 8'h64;
  localparam logic [7:0] FIX_INT_TRIP       = 8'h46;
  localparam logic [7:0] FIX_REM_TRIP       = 8'h64;
  localparam logic [7:0] RST_FAN_SPEED      = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT     = 8'h7F;
  localparam logic [7:0] RST_LOW_LIMIT      = 8'h80;
  localparam logic [7:0] RST_TEMP           = 8'h00;
  localparam logic [7:0] RST_CONFIG         = 8'h21;
  localparam logic [7:0] FAN_FULL_SPEED     = 8'hFF;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // configuration register layout, bit 7 first
  typedef struct packed {
    logic rsvd7;
    logic input_polarity_flip;
    logic fan_off;
    logic soft_reset;
    logic trip_lock;
    logic rsvd2;
    logic alert_enable;
    logic run;
  } tfv_cfg_s;

  // one conversion result pair
  typedef struct packed {
    logic [7:0] remote;
    logic [7:0] internal;
  } tfv_temp_s;

endpackage : tfv_pkg

// ---- tfv_regs.sv ----
// value and configuration registers of the thermal monitor / fan controller
`timescale 1ns/100ps
`default_nettype none

module tfv_regs
  import tfv_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  // register access port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  // conversion results
  input  wire logic       conv_done_in,
  input  wire tfv_temp_s  conv_temp_in,
  // general purpose input pin
  input  wire logic       general_purpose_input_pin_in,
  // outputs
  output logic      [7:0] fan_speed_level_out,
  output logic            over_temp_out,
  output logic            monitor_run_out,
  output logic            gpi_level_out,
  output logic            fan_off_drv_out,
  output logic            fan_off_oe_n_out,
  output logic            alert_drv_out,
  output logic            alert_oe_n_out
);

  // reset synchroniser
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin synchroniser for the general purpose input
  logic gpi_meta;
  logic gpi_sync;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      gpi_meta <= 1'b0;
      gpi_sync <= 1'b0;
    end else begin
      gpi_meta <= general_purpose_input_pin_in;
      gpi_sync <= gpi_meta;
    end
  end

  // storage
  tfv_cfg_s  cfg;
  tfv_temp_s temp;
  logic [7:0] int_trip_prog;
  logic [7:0] rem_trip_prog;
  logic [7:0] fan_speed;
  logic [7:0] rem_high;
  logic [7:0] rem_low;
  logic [7:0] int_high;
  logic [7:0] int_low;
  logic       alert_flag;
  logic       over_temp;

  logic      wr_cfg;
  tfv_cfg_s  wcfg;
  tfv_cfg_s  cfg_rst;
  logic      soft_rst;

  assign wr_cfg   = reg_wr_in && (reg_addr_in == ADDR_CONFIG);
  assign wcfg     = tfv_cfg_s'(reg_wdata_in);
  assign cfg_rst  = tfv_cfg_s'(RST_CONFIG);
  assign soft_rst = wr_cfg && wcfg.soft_reset;

  // configuration register
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= tfv_cfg_s'(RST_CONFIG);
    end else if (wr_cfg) begin
      if (wcfg.soft_reset) begin
        cfg           <= cfg_rst;
        cfg.trip_lock <= cfg.trip_lock;
      end else begin
        cfg.run          <= wcfg.run;
        cfg.alert_enable <= wcfg.alert_enable;
        cfg.fan_off      <= wcfg.fan_off;
        cfg.input_polarity_flip   <= wcfg.input_polarity_flip;
        cfg.trip_lock    <= cfg.trip_lock | wcfg.trip_lock;
      end
      cfg.soft_reset <= 1'b0;
      cfg.rsvd2      <= 1'b0;
      cfg.rsvd7      <= 1'b0;
    end
  end

  // trip points; here the lock only gates writes, it never clears a value
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_trip_prog <= RST_INT_TRIP_PROG;
      rem_trip_prog <= RST_REM_TRIP_PROG;
    end else if (reg_wr_in && !cfg.trip_lock) begin
      if (reg_addr_in == ADDR_INT_TRIP_PROG)
        int_trip_prog <= reg_wdata_in;
      if (reg_addr_in == ADDR_REM_TRIP_PROG)
        rem_trip_prog <= reg_wdata_in;
    end
  end

  // fan speed level and limits
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      fan_speed <= RST_FAN_SPEED;
      rem_high  <= RST_HIGH_LIMIT;
      rem_low   <= RST_LOW_LIMIT;
      int_high  <= RST_HIGH_LIMIT;
      int_low   <= RST_LOW_LIMIT;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_FAN_SPEED: fan_speed <= reg_wdata_in;
        ADDR_REM_HIGH:  rem_high  <= reg_wdata_in;
        ADDR_REM_LOW:   rem_low   <= reg_wdata_in;
        ADDR_INT_HIGH:  int_high  <= reg_wdata_in;
        ADDR_INT_LOW:   int_low   <= reg_wdata_in;
        default: ; // factory test and read-only locations take no write
      endcase
    end
  end

  // readings only move while running; standby freezes the last pair
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      temp <= {RST_TEMP, RST_TEMP};
    end else if (conv_done_in && cfg.run) begin
      temp <= conv_temp_in;
    end
  end

  // trip selection and comparisons
  logic [7:0] int_trip_eff;
  logic [7:0] rem_trip_eff;
  logic       next_over_temp;
  logic       limit_viol;
  logic       gpi_level;

  assign int_trip_eff = cfg.trip_lock ? int_trip_prog : FIX_INT_TRIP;
  assign rem_trip_eff =
    cfg.trip_lock ? rem_trip_prog : FIX_REM_TRIP;
  assign next_over_temp =
    ($signed(temp.internal) >= $signed(int_trip_eff)) ||
    ($signed(temp.remote)   >= $signed(rem_trip_eff));
  assign limit_viol =
    ($signed(conv_temp_in.internal) > $signed(int_high)) ||
    ($signed(conv_temp_in.internal) < $signed(int_low))  ||
    ($signed(conv_temp_in.remote)   > $signed(rem_high)) ||
    ($signed(conv_temp_in.remote)   < $signed(rem_low));
  assign gpi_level = gpi_sync ^ cfg.input_polarity_flip;

  // over-temperature state is not touched by soft reset
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      over_temp <= 1'b0;
    end else begin
      over_temp <= next_over_temp;
    end
  end

  // alert latch; a new cause in the soft reset cycle wins over the rearm
  logic alert_set;

  assign alert_set = (conv_done_in && cfg.run && limit_viol) || gpi_level;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      alert_flag <= 1'b0;
    end else if (alert_set) begin
      alert_flag <= 1'b1;
    end else if (soft_rst) begin
      alert_flag <= 1'b0;
    end
  end

  // fan-off buffer: stored bit kept so it comes back after over-temp ends
  logic fan_off_buf;

  assign fan_off_buf = cfg.fan_off | over_temp;

  // read port
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    tfv_cfg_s c;
    c            = cfg;
    c.fan_off    = fan_off_buf;
    c.soft_reset = 1'b0;
    c.rsvd2      = 1'b0;
    c.rsvd7      = 1'b0;
    case (a)
      ADDR_INT_TRIP_PROG: read_mux = int_trip_prog;
      ADDR_REM_TRIP_PROG: read_mux = rem_trip_prog;
      ADDR_FACTORY_TEST:  read_mux = READ_ZERO;
      ADDR_INT_TRIP_FIX:  read_mux = FIX_INT_TRIP;
      ADDR_REM_TRIP_FIX:  read_mux = FIX_REM_TRIP;
      ADDR_FAN_SPEED:     read_mux = fan_speed;
      ADDR_REM_TEMP:      read_mux = temp.remote;
      ADDR_INT_TEMP:      read_mux = temp.internal;
      ADDR_REM_HIGH:      read_mux = rem_high;
      ADDR_REM_LOW:       read_mux = rem_low;
      ADDR_INT_HIGH:      read_mux = int_high;
      ADDR_INT_LOW:       read_mux = int_low;
      ADDR_CONFIG:        read_mux = c;
      default:            read_mux = READ_ZERO;
    endcase
  endfunction : read_mux

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out  <= READ_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= read_mux(reg_addr_in);
    end
  end

  // registered outputs; open-drain pins only ever pull low
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      fan_speed_level_out <= RST_FAN_SPEED;
      over_temp_out       <= 1'b0;
      monitor_run_out     <= 1'b0;
      gpi_level_out       <= 1'b0;
      fan_off_drv_out     <= 1'b0;
      fan_off_oe_n_out    <= 1'b1;
      alert_drv_out       <= 1'b0;
      alert_oe_n_out      <= 1'b1;
    end else begin
      fan_speed_level_out <= over_temp ? FAN_FULL_SPEED : fan_speed;
      over_temp_out       <= over_temp;
      monitor_run_out     <= cfg.run;
      gpi_level_out       <= gpi_level;
      fan_off_drv_out     <= 1'b0;
      fan_off_oe_n_out    <= fan_off_buf;
      alert_drv_out       <= 1'b0;
      alert_oe_n_out      <= !(cfg.alert_enable && alert_flag);
    end
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  chk_trip_write_lock: assert property (
    reg_wr_in && reg_addr_in == ADDR_INT_TRIP_PROG && cfg.trip_lock
    |=> $stable(int_trip_prog))
    else $error("internal trip changed while locked");

  chk_rem_trip_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_REM_TRIP_PROG && !cfg.trip_lock
    |=> rem_trip_prog == $past(reg_wdata_in))
    else $error("remote trip write lost while unlocked");

  chk_lock_sticky: assert property (
    cfg.trip_lock |=> cfg.trip_lock)
    else $error("trip lock cleared without reset pin");

  chk_soft_self_clear: assert property (
    soft_rst |=> !cfg.soft_reset ##1 !cfg.soft_reset)
    else $error("soft reset bit did not clear");

  chk_soft_restore: assert property (
    soft_rst |=> cfg.run && !cfg.alert_enable && cfg.fan_off
                 && !cfg.input_polarity_flip)
    else $error("soft reset did not restore configuration");

  chk_alert_gated: assert property (
    !cfg.alert_enable |=> alert_oe_n_out)
    else $error("alert driven while disabled");

  chk_fan_off_force: assert property (
    over_temp |=> fan_off_oe_n_out)
    else $error("fan-off driven low during over-temperature");

  chk_fan_off_restore: assert property (
    $fell(over_temp) && !cfg.fan_off && !wr_cfg |=> !fan_off_oe_n_out ##0
    fan_off_oe_n_out == 1'b0)
    else $error("fan-off not restored after over-temperature");

  chk_standby_frozen: assert property (
    !cfg.run |=> $stable(temp))
    else $error("reading moved in standby");

  chk_read_reserved: assert property (
    reg_rd_in && reg_addr_in == ADDR_CONFIG
    |=> reg_rvalid_out && reg_rdata_out[7] == 1'b0
        && reg_rdata_out[2] == 1'b0 && reg_rdata_out[4] == 1'b0)
    else $error("reserved or soft reset bit read nonzero");

  chk_fixed_trip: assert property (
    !cfg.trip_lock && $signed(temp.remote) >= $signed(FIX_REM_TRIP)
    |=> over_temp ##1 over_temp_out)
    else $error("fixed remote trip not applied");

  cov_lock_set: cover property (!cfg.trip_lock ##1 cfg.trip_lock);
  cov_over_temp: cover property (
    $rose(over_temp_out) ##[1:20] $fell(over_temp_out));
  cov_alert: cover property (cfg.alert_enable && $fell(alert_oe_n_out));
  cov_soft_reset: cover property (soft_rst && alert_flag);

endmodule : tfv_regs

`default_nettype wire

// ---- tfv_regs_bench.sv ----
// self-checking bench for the value and configuration register bank
`timescale 1ns/100ps
`default_nettype none

module tfv_regs_bench
  import tfv_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr, wdata, rdata, fan;
  logic       wr, rd, rvalid, ot, run, gpil;
  logic       fdrv, foe, adrv, aoe;
  logic       conv = 1'b0;
  logic       general_purpose_input_pin = 1'b0;
  tfv_temp_s  temp = '0;
  int         error_cnt = 0;
  int         checks_done = 0;

  always #5 clk = ~clk;

  tfv_regs uut (.mclk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .conv_done_in(conv), .conv_temp_in(temp),
    .general_purpose_input_pin_in(general_purpose_input_pin), .fan_speed_level_out(fan),
    .over_temp_out(ot), .monitor_run_out(run), .gpi_level_out(gpil),
    .fan_off_drv_out(fdrv), .fan_off_oe_n_out(foe),
    .alert_drv_out(adrv), .alert_oe_n_out(aoe));

  tfv_host_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr),
    .wdata_out(wdata), .rd_out(rd), .rdata_in(rdata),
    .rvalid_in(rvalid));

  task automatic complete_run;
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk(d, e);
  endtask : rc

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    host.wr_reg(a, d);
    wait_n(2);
  endtask : wr2

  // over-temp output lags the accepting edge by two
  task automatic cv(input logic [7:0] r, input logic [7:0] i);
    @(posedge clk);
    conv <= 1'b1;
    temp <= '{remote: r, internal: i};
    @(posedge clk);
    conv <= 1'b0;
    wait_n(3);
  endtask : cv

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    wait_n(3);
  endtask : do_reset

  task automatic t_defaults;
    rc(ADDR_INT_TRIP_PROG, 8'h7F);
    rc(ADDR_REM_TRIP_PROG, 8'h64);
    rc(ADDR_INT_TRIP_FIX, 8'h46);
    rc(ADDR_REM_TRIP_FIX, 8'h64);
    rc(ADDR_FAN_SPEED, 8'h00);
    rc(ADDR_REM_HIGH, 8'h7F);
    rc(ADDR_REM_LOW, 8'h80);
    rc(ADDR_INT_HIGH, 8'h7F);
    rc(ADDR_INT_LOW, 8'h80);
    rc(ADDR_CONFIG, 8'h21);
    chk({3'h0, run, foe, aoe, fdrv, adrv}, 8'h1C);
  endtask : t_defaults

  task automatic t_values;
    logic [7:0] a[7] = '{8'h19, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h13, 8'h14};
    logic [7:0] v[7] = '{8'h5A, 8'h7E, 8'h81, 8'h7E, 8'h81, 8'h50, 8'h70};
    for (int k = 0; k < 7; k++) host.wr_reg(a[k], v[k]);
    for (int k = 0; k < 7; k++) rc(a[k], v[k]);
    chk(fan, 8'h5A);
    wr2(ADDR_INT_TRIP_FIX, 8'h00);
    rc(ADDR_INT_TRIP_FIX, 8'h46);
    wr2(ADDR_REM_TRIP_FIX, 8'h00);
    rc(ADDR_REM_TRIP_FIX, 8'h64);
  endtask : t_values

  task automatic t_standby_gpi;
    @(posedge clk);
    general_purpose_input_pin <= 1'b1;
    wait_n(6);
    chk({7'h0, gpil}, 8'h01);
    wr2(ADDR_CONFIG, 8'hC4);
    rc(ADDR_CONFIG, 8'h40);
    wait_n(4);
    chk({5'h0, run, foe, gpil}, 8'h00);
    cv(8'h33, 8'h33);
    rc(ADDR_REM_TEMP, RST_TEMP);
    @(posedge clk);
    general_purpose_input_pin <= 1'b0;
    wr2(ADDR_CONFIG, 8'h01);
  endtask : t_standby_gpi

  task automatic t_overtemp;
    cv(8'h30, 8'h20);
    rc(ADDR_REM_TEMP, 8'h30);
    rc(ADDR_INT_TEMP, 8'h20);
    chk({7'h0, ot}, 8'h00);
    cv(8'h64, 8'h20);
    chk({6'h0, ot, foe}, 8'h03);
    chk(fan, 8'hFF);
    rc(ADDR_CONFIG, 8'h21);
    cv(8'h10, 8'h20);
    chk({6'h0, ot, foe}, 8'h00);
    chk(fan, 8'h5A);
    rc(ADDR_CONFIG, 8'h01);
    cv(8'h10, 8'h46);
    chk({7'h0, ot}, 8'h01);
    cv(8'h10, 8'h45);
    chk({7'h0, ot}, 8'h00);
  endtask : t_overtemp

  task automatic t_lock;
    wr2(ADDR_CONFIG, 8'h09);
    host.wr_reg(ADDR_INT_TRIP_PROG, 8'h11);
    host.wr_reg(ADDR_REM_TRIP_PROG, 8'h11);
    rc(ADDR_INT_TRIP_PROG, 8'h50);
    rc(ADDR_REM_TRIP_PROG, 8'h70);
    wr2(ADDR_CONFIG, 8'h01);
    rc(ADDR_CONFIG, 8'h09);
    cv(8'h68, 8'h46);
    chk({7'h0, ot}, 8'h00);
    cv(8'h70, 8'h20);
    chk({7'h0, ot}, 8'h01);
    cv(8'h10, 8'h20);
  endtask : t_lock

  task automatic t_alert;
    wr2(ADDR_INT_HIGH, 8'h20);
    wr2(ADDR_CONFIG, 8'h10);
    rc(ADDR_CONFIG, 8'h29);
    wr2(ADDR_CONFIG, 8'h2B);
    chk({7'h0, aoe}, 8'h01);
    cv(8'h10, 8'h30);
    chk({7'h0, aoe}, 8'h00);
    wr2(ADDR_CONFIG, 8'h29);
    chk({7'h0, aoe}, 8'h01);
    wr2(ADDR_CONFIG, 8'h10);
    wr2(ADDR_CONFIG, 8'h2B);
    chk({7'h0, aoe}, 8'h01);
    do_reset();
    rc(ADDR_CONFIG, 8'h21);
  endtask : t_alert

  // generous bound: the full sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    do_reset();
    t_defaults();
    t_values();
    t_standby_gpi();
    t_overtemp();
    t_lock();
    t_alert();
    complete_run();
  end
endmodule : tfv_regs_bench

`default_nettype wire
